//--- hw/cover_port_pkg.sv
package cover_port_pkg;
	// Register indices; the byte address would be four times the index
	localparam logic [6:0] ADDR_REF_CONF  = 7'h01;
	localparam logic [6:0] ADDR_SPI_CONF  = 7'h04;
	localparam logic [6:0] ADDR_STEP_CONFIG = 7'h0a;
	localparam logic [6:0] ADDR_EVENTS    = 7'h0e;
	localparam logic [6:0] ADDR_STATUS    = 7'h0f;
	localparam logic [6:0] ADDR_SW_VEL    = 7'h1d;
	localparam logic [6:0] ADDR_TX_LOW    = 7'h6c;
	localparam logic [6:0] ADDR_TX_HIGH   = 7'h6d;
	localparam logic [6:0] ADDR_RX_LOW    = 7'h6e;
	localparam logic [6:0] ADDR_RX_HIGH   = 7'h6f;

	// Field positions
	localparam int AUTO_COVER_BIT = 28;
	localparam int FMT_LSB        = 0;
	localparam int LOWT_LSB       = 4;
	localparam int HIGHT_LSB      = 8;
	localparam int LEN_LSB        = 13;
	localparam int BLOCKT_LSB     = 24;
	localparam int SEL_LSB        = 16;
	localparam int DRV_STAT_LSB   = 24;
	localparam int EV_COVER_DONE  = 25;
	localparam int EV_MOTOR       = 30;

	// Reset values
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [31:0] RST_SPI    = 32'h0000_0000;

	// Driver formats and their automatic lengths
	localparam logic [3:0] FMT_OFF = 4'h0;
	localparam logic [6:0] LEN_12  = 7'h0c;
	localparam logic [6:0] LEN_20  = 7'h14;
	localparam logic [6:0] LEN_40  = 7'h28;
	localparam logic [6:0] LEN_MAX = 7'h40;
	localparam logic [6:0] LEN_AUTO_LIMIT = 7'h20;
endpackage

//--- hw/driver_cover_datagram_port.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Functional notes
// R1: LSB at low cover bit zero; low only
// R2: Over 32 bits, low plus lower high bits
// R3: Every datagram shifts MSB first
// R4: Low cover write starts configured-length transfer
// R5: Software writes high before low
// R6: Length above 64 clamps to 64
// R7: Reply captured into response register pair
// R8: Response uses transmit arrangement, LSB at zero
// R9: Cover-done flag set after response stored
// R10: Velocity auto cover only up to 32 bits
// R11: Threshold register and auto-cover enable bit
// R12: Crossing sends low below, high at/above
// R13: Length field 19:13, zero means automatic
// R14: Format field 3:0, zero switches off
// R15: Auto lengths 12, 20, 40 per format
// R16: Separate low, high and block times
// R17: Current datagram replies also stored
// R18: Driver status bits into status 31:24
// R19: Motor event bit 30 from status
// R20: Event is OR of selected status bits
// R21: Busy-time cover request waits, not lost
module driver_cover_datagram_port
	import cover_port_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	// Register port
	input  wire logic [6:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Ramp and current datagram source
	input  wire logic [31:0] ramp_velocity_i,
	input  wire logic        cur_req_i,
	input  wire logic [63:0] cur_data_i,
	// Driver link
	output logic             spi_sck_o,
	output logic             spi_cs_n_o,
	output logic             spi_mosi_o,
	input  wire logic        spi_miso_i
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_BLOCK} link_state_e;

	// Software registers
	logic [31:0] ref_conf_q;    // Reference configuration
	logic [31:0] spi_conf_q;    // Output configuration
	logic [31:0] step_config_q;   // Step configuration, holds event select
	logic [31:0] sw_vel_q;      // Velocity threshold
	logic [31:0] tx_low_q;      // Cover word, low part
	logic [31:0] tx_high_q;     // Cover word, high part
	logic [31:0] rx_low_q;      // Reply, low part
	logic [31:0] rx_high_q;     // Reply, high part
	logic [7:0]  drv_stat_q;    // Last driver status bits
	logic        ev_done_q;     // Sticky cover-done event
	logic        ev_motor_q;    // Sticky motor event
	logic [31:0] rdata_q;       // Read data, one cycle late

	// Link state
	link_state_e state_q;
	logic [63:0] tx_sr_q;       // Outgoing shifter, MSB at top
	logic [63:0] rx_sr_q;       // Incoming shifter
	logic [6:0]  bits_q;        // Bits still to shift
	logic [6:0]  len_q;         // Length of the running datagram
	logic [3:0]  tim_q;         // Phase timer
	logic        is_cover_q;    // Running datagram is a cover
	logic        sck_q;
	logic        csn_q;
	logic        miso_m_q;      // Synchroniser first stage
	logic        miso_s_q;      // Synchroniser second stage

	// Pending requests
	logic        man_pend_q;    // Software cover waiting
	logic        auto_pend_q;   // Velocity cover waiting
	logic        auto_hi_q;     // Velocity cover picks the high word
	logic        cur_pend_q;    // Current datagram waiting
	logic [63:0] cur_buf_q;     // Held current datagram
	logic        above_q;       // Last side of the threshold

	// Configuration decode
	logic [3:0]  fmt;
	logic [6:0]  len_field;
	logic [6:0]  auto_len;
	logic [6:0]  cover_len;
	logic [31:0] abs_vel;
	logic        above_now;
	logic        wr_low;
	logic        start_ok;
	logic [63:0] cover_word;
	logic [63:0] cover_sel;
	logic [7:0]  rx_stat;

	assign fmt       = spi_conf_q[FMT_LSB +: 4];      // R14
	assign len_field = spi_conf_q[LEN_LSB +: 7];      // R13

	// Automatic length per driver format
	always_comb begin
		case (fmt) // R15
			4'h8, 4'h9: auto_len = LEN_12;
			4'ha, 4'hb: auto_len = LEN_20;
			4'hc, 4'hd: auto_len = LEN_40;
			default:    auto_len = 7'h00;
		endcase
	end

	// Programmed length, zero picks automatic, clamped at 64
	always_comb begin
		if (len_field == 7'h00) begin // R13
			cover_len = auto_len;
		end else if (len_field > LEN_MAX) begin
			cover_len = LEN_MAX; // R6
		end else begin
			cover_len = len_field;
		end
	end

	// Combined cover word: low at bit zero, high above it
	assign cover_word = {tx_high_q, tx_low_q}; // R1 R2
	// Velocity covers use one 32-bit word only
	assign cover_sel  = auto_hi_q ? {32'h0000_0000, tx_high_q}
	                              : {32'h0000_0000, tx_low_q}; // R12

	// Magnitude of the ramp velocity, two's complement input
	assign abs_vel   = ramp_velocity_i[31] ? (~ramp_velocity_i + 32'h0000_0001)
	                                       : ramp_velocity_i;
	assign above_now = abs_vel >= sw_vel_q; // R12

	assign wr_low   = reg_wr_i && (reg_addr_i == ADDR_TX_LOW);
	assign start_ok = (state_q == ST_IDLE) && (fmt != FMT_OFF);

	// Reply status: lowest eight received bits
	assign rx_stat = rx_sr_q[7:0];

	// Configuration register writes
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ref_conf_q  <= RST_ZERO;
			spi_conf_q  <= RST_SPI;
			step_config_q <= RST_ZERO;
			sw_vel_q    <= RST_ZERO;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_REF_CONF:  ref_conf_q  <= reg_wdata_i; // R11
				ADDR_SPI_CONF:  spi_conf_q  <= reg_wdata_i;
				ADDR_STEP_CONFIG: step_config_q <= reg_wdata_i; // R20
				ADDR_SW_VEL:    sw_vel_q    <= reg_wdata_i; // R11
				default:        ;
			endcase
		end
	end

	// Cover words, stored as written
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			tx_low_q  <= RST_ZERO;
			tx_high_q <= RST_ZERO;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_TX_LOW) begin
				tx_low_q <= reg_wdata_i;
			end
			// High word is only latched; it never starts a send
			if (reg_addr_i == ADDR_TX_HIGH) begin
				tx_high_q <= reg_wdata_i; // R5
			end
		end
	end

	// Read data, valid in the cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_q <= RST_ZERO;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_REF_CONF:  rdata_q <= ref_conf_q;
				ADDR_SPI_CONF:  rdata_q <= spi_conf_q;
				ADDR_STEP_CONFIG: rdata_q <= step_config_q;
				ADDR_SW_VEL:    rdata_q <= sw_vel_q;
				ADDR_TX_LOW:    rdata_q <= tx_low_q;
				ADDR_TX_HIGH:   rdata_q <= tx_high_q;
				ADDR_RX_LOW:    rdata_q <= rx_low_q;  // R7
				ADDR_RX_HIGH:   rdata_q <= rx_high_q; // R7
				ADDR_STATUS: begin
					rdata_q <= {drv_stat_q, 24'h00_0000}; // R18
				end
				ADDR_EVENTS: begin
					rdata_q <= {1'b0, ev_motor_q, 4'h0, ev_done_q, 25'h000_0000};
				end
				default:        rdata_q <= RST_ZERO; // Unmapped reads as zero
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;

	// Software cover request; waits while the link is busy
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			man_pend_q <= 1'b0;
		end else if (wr_low && (fmt != FMT_OFF)) begin
			man_pend_q <= 1'b1; // R4 R21
		end else if (start_ok) begin
			man_pend_q <= 1'b0;
		end
	end

	// Threshold crossing detector for velocity covers
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			above_q     <= 1'b0;
			auto_pend_q <= 1'b0;
			auto_hi_q   <= 1'b0;
		end else begin
			above_q <= above_now;
			// A new crossing replaces an older unsent one
			if ((above_now != above_q) && ref_conf_q[AUTO_COVER_BIT]
			    && (cover_len <= LEN_AUTO_LIMIT) && (fmt != FMT_OFF)) begin
				auto_pend_q <= 1'b1; // R10 R12
				auto_hi_q   <= above_now;
			end else if (start_ok && !man_pend_q) begin
				auto_pend_q <= 1'b0;
			end
		end
	end

	// Current datagram request holding
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			cur_pend_q <= 1'b0;
			cur_buf_q  <= 64'h0000_0000_0000_0000;
		end else if (cur_req_i && (fmt != FMT_OFF)) begin
			cur_pend_q <= 1'b1;
			cur_buf_q  <= cur_data_i;
		end else if (start_ok && !man_pend_q && !auto_pend_q) begin
			cur_pend_q <= 1'b0;
		end
	end

	// Miso passes two flops before use
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end else begin
			miso_m_q <= spi_miso_i;
			miso_s_q <= miso_m_q;
		end
	end

	// Link sequencer: covers beat current datagrams in priority
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state_q    <= ST_IDLE;
			tx_sr_q    <= 64'h0000_0000_0000_0000;
			rx_sr_q    <= 64'h0000_0000_0000_0000;
			bits_q     <= 7'h00;
			len_q      <= 7'h00;
			tim_q      <= 4'h0;
			is_cover_q <= 1'b0;
			sck_q      <= 1'b0;
			csn_q      <= 1'b1;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sck_q <= 1'b0;
					csn_q <= 1'b1;
					// Zero length would wrap the bit count and run 128 bits; such a request is dropped
					if (start_ok && (man_pend_q || auto_pend_q) && (cover_len != 7'h00)) begin
						// Left-align so the top bit leaves first
						tx_sr_q <= (man_pend_q ? cover_word : cover_sel)
						           << (LEN_MAX - cover_len); // R3 R2
						len_q      <= cover_len;
						bits_q     <= cover_len; // R4
						is_cover_q <= 1'b1;
						rx_sr_q    <= 64'h0000_0000_0000_0000;
						tim_q      <= spi_conf_q[LOWT_LSB +: 4]; // R16
						csn_q      <= 1'b0;
						state_q    <= ST_LOW;
					end else if (start_ok && cur_pend_q && (auto_len != 7'h00)) begin
						tx_sr_q    <= cur_buf_q << (LEN_MAX - auto_len); // R3
						len_q      <= auto_len;
						bits_q     <= auto_len;
						is_cover_q <= 1'b0;
						rx_sr_q    <= 64'h0000_0000_0000_0000;
						tim_q      <= spi_conf_q[LOWT_LSB +: 4];
						csn_q      <= 1'b0;
						state_q    <= ST_LOW;
					end
				end
				ST_LOW: begin
					// Clock low phase, data already stable
					if (tim_q == 4'h0) begin
						sck_q   <= 1'b1;
						tim_q   <= spi_conf_q[HIGHT_LSB +: 4]; // R16
						state_q <= ST_HIGH;
					end else begin
						tim_q <= tim_q - 4'h1;
					end
				end
				ST_HIGH: begin
					// Sample at the end of the high phase
					if (tim_q == 4'h0) begin
						sck_q   <= 1'b0;
						rx_sr_q <= {rx_sr_q[62:0], miso_s_q}; // R8
						tx_sr_q <= {tx_sr_q[62:0], 1'b0};     // R3
						bits_q  <= bits_q - 7'h01;
						if (bits_q == 7'h01) begin
							csn_q   <= 1'b1;
							tim_q   <= spi_conf_q[BLOCKT_LSB +: 4]; // R16
							state_q <= ST_BLOCK;
						end else begin
							tim_q   <= spi_conf_q[LOWT_LSB +: 4];
							state_q <= ST_LOW;
						end
					end else begin
						tim_q <= tim_q - 4'h1;
					end
				end
				ST_BLOCK: begin
					// Gap between datagrams; new requests wait for it
					if (tim_q == 4'h0) begin
						state_q <= ST_IDLE; // R21
					end else begin
						tim_q <= tim_q - 4'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign spi_sck_o  = sck_q;
	assign spi_cs_n_o = csn_q;
	assign spi_mosi_o = tx_sr_q[63];

	// Reply store, once per finished datagram of either kind
	logic store_pulse;
	logic done_arm_q;   // One store per datagram
	assign store_pulse = (state_q == ST_BLOCK) && (tim_q == spi_conf_q[BLOCKT_LSB +: 4])
	                     && csn_q && (len_q != 7'h00) && done_arm_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			done_arm_q <= 1'b0;
		end else if (state_q == ST_LOW) begin
			done_arm_q <= 1'b1;
		end else if (store_pulse) begin
			done_arm_q <= 1'b0;
		end
	end

	// Response pair and driver status
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rx_low_q   <= RST_ZERO;
			rx_high_q  <= RST_ZERO;
			drv_stat_q <= 8'h00;
		end else if (store_pulse) begin
			rx_low_q   <= rx_sr_q[31:0];  // R7 R8 R17
			rx_high_q  <= rx_sr_q[63:32]; // R7 R8 R17
			drv_stat_q <= rx_stat;        // R18
		end
	end

	// Sticky events; a set in the clearing cycle wins
	logic ev_clear;
	assign ev_clear = reg_rd_i && (reg_addr_i == ADDR_EVENTS);
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ev_done_q  <= 1'b0;
			ev_motor_q <= 1'b0;
		end else begin
			if (store_pulse && is_cover_q) begin
				ev_done_q <= 1'b1; // R9
			end else if (ev_clear) begin
				ev_done_q <= 1'b0;
			end
			if (store_pulse && |(rx_stat & step_config_q[SEL_LSB +: 8])) begin
				ev_motor_q <= 1'b1; // R19 R20
			end else if (ev_clear) begin
				ev_motor_q <= 1'b0;
			end
		end
	end
endmodule

//--- sim/cover_port_props.sv
`timescale 1ns/1ps
// Port-level checker for the cover datagram port
module cover_port_props
	import cover_port_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	// Register port
	input wire logic [6:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// Link
	input wire logic        cur_req_i,
	input wire logic        spi_sck_o,
	input wire logic        spi_cs_n_o,
	input wire logic        spi_mosi_o
);
	logic [31:0] conf_q;  // Shadow of output config
	logic        cur_q;   // Current datagram seen; its length differs
	logic        sck_q;   // Link clock one cycle back
	logic [7:0]  run_q;   // Cycles at present link clock level
	logic [7:0]  csrun_q; // Idle cycles, saturating
	logic [7:0]  bits_q;  // Link clock rises in frame

	// Frame length the config asks for
	function automatic logic [7:0] exp_len(input logic [31:0] c);
		if (c[LEN_LSB +: 7] > LEN_MAX) return {1'b0, LEN_MAX};
		if (c[LEN_LSB +: 7] != 7'h00) return {1'b0, c[LEN_LSB +: 7]};
		case (c[3:1])
			3'h4: return {1'b0, LEN_12};
			3'h5: return {1'b0, LEN_20};
			3'h6: return {1'b0, LEN_40};
			default: return 8'h00;
		endcase
	endfunction

	// Config shadow and current request flag
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			conf_q <= 32'h0;
			cur_q  <= 1'b0;
		end else begin
			if (reg_wr_i && reg_addr_i == ADDR_SPI_CONF) begin
				conf_q <= reg_wdata_i;
			end
			if (cur_req_i) begin
				cur_q <= 1'b1;
			end
		end
	end

	// Run lengths and bit count
	always_ff @(posedge clk_sys_i) begin
		sck_q  <= spi_sck_o;
		run_q  <= (spi_sck_o != sck_q) ? 8'h01 : run_q + 8'h01;
		bits_q <= spi_cs_n_o ? 8'h00 : bits_q + {7'h0, spi_sck_o && !sck_q};
		if (!rstn_i || (spi_cs_n_o && csrun_q == 8'hff)) begin
			csrun_q <= 8'hff;
		end else begin
			csrun_q <= spi_cs_n_o ? csrun_q + 8'h01 : 8'h00;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	sequence s_cover_wr;
		reg_wr_i && reg_addr_i == ADDR_TX_LOW && conf_q[3:0] != FMT_OFF && exp_len(conf_q) != 8'h00;
	endsequence
	sequence s_frame_start;
		$fell(spi_cs_n_o);
	endsequence

	AST_START: assert property (s_cover_wr |-> ##[2:1000] s_frame_start)
		else $error("cover write did not start a frame");
	AST_FMT_OFF: assert property (conf_q[3:0] == FMT_OFF && spi_cs_n_o |=> spi_cs_n_o)
		else $error("frame started with output off");
	AST_CS_IDLE: assert property (spi_cs_n_o |-> !spi_sck_o)
		else $error("link clock high while deselected");
	AST_MOSI_EDGE: assert property (!spi_cs_n_o && !$fell(spi_cs_n_o) && $changed(spi_mosi_o)
		|-> $fell(spi_sck_o))
		else $error("data changed off the falling link clock");
	AST_HIGH_TIME: assert property (sck_q && !spi_sck_o && !spi_cs_n_o
		|-> run_q == {4'h0, conf_q[HIGHT_LSB +: 4]} + 8'h01)
		else $error("link clock high phase length wrong");
	AST_BLOCK: assert property (s_frame_start |-> csrun_q > {4'h0, conf_q[BLOCKT_LSB +: 4]})
		else $error("block time between frames too short");
	AST_LEN: assert property ($rose(spi_cs_n_o) && !cur_q |-> bits_q == exp_len(conf_q))
		else $error("frame bit count wrong");
	AST_RD_HOLD: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
		else $error("read data moved without a read");
endmodule

bind driver_cover_datagram_port cover_port_props u_props (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .cur_req_i(cur_req_i), .spi_sck_o(spi_sck_o),
	.spi_cs_n_o(spi_cs_n_o), .spi_mosi_o(spi_mosi_o)
);

//--- sim/drv_model.sv
`timescale 1ns/1ps
// Behavioural motor driver at the far end of the link
module drv_model (
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic [63:0] reply_i,
	input  wire logic [6:0]  len_i,
	output logic             miso_o,
	output logic [63:0]      rx_o,
	output int               frames_o
);
	logic [63:0] sh; // Reply shifter, MSB goes out first

	initial begin
		miso_o   = 1'b0;
		rx_o     = 64'h0;
		frames_o = 0;
		sh       = 64'h0;
	end
	// Selected: load reply left aligned, first bit out at once
	always @(negedge cs_n_i) begin
		sh     = reply_i << (7'h40 - len_i);
		miso_o = sh[63];
		rx_o   = 64'h0;
	end
	// Host bit taken on the rising link clock
	always @(posedge sck_i) begin
		if (!cs_n_i) rx_o = {rx_o[62:0], mosi_i};
	end
	// Next reply bit after the falling link clock
	always @(negedge sck_i) begin
		if (!cs_n_i) begin
			sh     = sh << 1;
			miso_o = sh[63];
		end
	end
	// Released line is not held: flip it so stale data cannot pass
	always @(posedge cs_n_i) begin
		miso_o = ~miso_o;
		frames_o++;
	end
endmodule

//--- sim/test_driver_cover_datagram_port.sv
`timescale 1ns/1ps
module test_driver_cover_datagram_port
	import cover_port_pkg::*;
;
	typedef struct {logic [3:0] fmt; logic [6:0] len; logic [6:0] eff;} row_s;
	logic clk_sys_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, cur_req = 1'b0, miso;
	logic [6:0]  addr = 7'h0;
	logic [31:0] wdata = 32'h0, vel = 32'h0, rdata;
	logic [63:0] cur_data = 64'h0, reply = 64'h0, rx, tx, m;
	logic        sck, cs_n, mosi;
	logic [6:0]  mlen = 7'h40;
	int          frames, f0, cyc = 0, n_mismatch = 0, compares = 0;
	row_s        rows [11];
	logic [31:0] vv [4] = '{32'd1500, 32'd10, -32'sd2000, -32'sd999};

	driver_cover_datagram_port u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .ramp_velocity_i(vel), .cur_req_i(cur_req),
		.cur_data_i(cur_data), .spi_sck_o(sck), .spi_cs_n_o(cs_n),
		.spi_mosi_o(mosi), .spi_miso_i(miso));
	drv_model u_drv (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .reply_i(reply),
		.len_i(mlen), .miso_o(miso), .rx_o(rx), .frames_o(frames));

	// 100 MHz clock
	always #5 clk_sys_i = ~clk_sys_i;
	// Hang guard, well above the expected run
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// Writes may follow each other; idle() lowers the strobe
	task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e, input logic [31:0] k,
		input string n);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		@(posedge clk_sys_i);
		chk(n, {32'h0, e & k}, {32'h0, rdata & k});
	endtask
	// Bounded wait for the next frame plus its block time
	task automatic wait_frame(input int f);
		idle(1);
		for (int i = 0; i < 2000 && frames == f; i++) @(posedge clk_sys_i);
		repeat (8) @(posedge clk_sys_i);
	endtask
	// Block 3, high 3, low 3: link clock period 80 ns
	function automatic logic [31:0] cfg(input logic [3:0] f, input logic [6:0] l);
		return 32'h0300_0330 | {12'h0, l, 13'h0} | {28'h0, f};
	endfunction
	task automatic end_sim();
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		rows = '{'{4'h1, 7'h08, 7'h08}, '{4'h1, 7'h20, 7'h20}, '{4'h1, 7'h21, 7'h21},
			'{4'h1, 7'h40, 7'h40}, '{4'h1, 7'h64, 7'h40}, '{4'h8, 7'h00, 7'h0c},
			'{4'h9, 7'h00, 7'h0c}, '{4'ha, 7'h00, 7'h14}, '{4'hb, 7'h00, 7'h14},
			'{4'hc, 7'h00, 7'h28}, '{4'hd, 7'h00, 7'h28}};
		repeat (12) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		wr_reg(ADDR_STEP_CONFIG, 32'h0005_0000);
		foreach (rows[i]) begin
			tx = 64'h9e37_79b9_7f4a_7c15 * (i + 1);
			reply = tx ^ 64'h5a5a_a5a5_0f0f_f0f3;
			mlen = rows[i].eff;
			m = (mlen == 7'h40) ? '1 : (64'h1 << mlen) - 64'h1;
			wr_reg(ADDR_SPI_CONF, cfg(rows[i].fmt, rows[i].len));
			wr_reg(ADDR_TX_HIGH, tx[63:32]);
			f0 = frames;
			wr_reg(ADDR_TX_LOW, tx[31:0]);
			wait_frame(f0);
			chk("frames", 64'(f0 + 1), 64'(frames));
			chk("sent", tx & m, rx);
			rd_chk(ADDR_RX_LOW, reply[31:0] & m[31:0], '1, "rx_low");
			rd_chk(ADDR_RX_HIGH, reply[63:32] & m[63:32], '1, "rx_high");
			rd_chk(ADDR_STATUS, {reply[7:0], 24'h0}, 32'hff00_0000, "status");
			rd_chk(ADDR_EVENTS, {1'b0, |(reply[7:0] & 8'h05), 5'h01, 25'h0}, 32'h4200_0000,
				"events");
		end
		// Read-only and unmapped places
		wr_reg(ADDR_RX_LOW, 32'hffff_ffff);
		rd_chk(ADDR_RX_LOW, reply[31:0] & m[31:0], '1, "rx_low_ro");
		rd_chk(7'h7f, 32'h0, '1, "unmapped");
		// Output off: word kept, nothing sent
		wr_reg(ADDR_SPI_CONF, cfg(4'h0, 7'h08));
		f0 = frames;
		wr_reg(ADDR_TX_LOW, 32'h0000_00a5);
		idle(100);
		chk("off_frames", 64'(f0), 64'(frames));
		rd_chk(ADDR_TX_LOW, 32'h0000_00a5, '1, "tx_low");
		// Velocity covers, 16 bits, threshold 1000
		mlen = 7'h10;
		wr_reg(ADDR_SPI_CONF, cfg(4'h1, 7'h10));
		wr_reg(ADDR_SW_VEL, 32'd1000);
		wr_reg(ADDR_TX_HIGH, 32'h0000_beef);
		f0 = frames;
		wr_reg(ADDR_TX_LOW, 32'h0000_1234);
		wait_frame(f0);
		wr_reg(ADDR_REF_CONF, 32'h1000_0000);
		rd_chk(ADDR_REF_CONF, 32'h1000_0000, '1, "ref_conf");
		rd_chk(ADDR_SW_VEL, 32'd1000, '1, "sw_vel");
		for (int k = 0; k < 4; k++) begin
			f0 = frames;
			vel <= vv[k];
			wait_frame(f0);
			chk("vel_frame", {48'h0, (k % 2) ? 16'h1234 : 16'hbeef}, rx);
		end
		// Over 32 bits no velocity cover
		wr_reg(ADDR_SPI_CONF, cfg(4'h1, 7'h21));
		f0 = frames;
		vel <= 32'd1500;
		idle(200);
		chk("vel_long", 64'(f0), 64'(frames));
		// Cover behind a current datagram waits, both replies stored
		mlen = 7'h28;
		wr_reg(ADDR_REF_CONF, 32'h0);
		wr_reg(ADDR_SPI_CONF, cfg(4'hc, 7'h00));
		idle(1);
		f0 = frames;
		reply <= 64'h0000_0024_6813_579b;
		cur_data <= 64'h0000_00c3_5a69_0f1e;
		cur_req <= 1'b1;
		@(posedge clk_sys_i);
		cur_req <= 1'b0;
		wr_reg(ADDR_TX_LOW, 32'h1122_3344);
		idle(1);
		// Different reply for the cover, so each store is told apart
		reply <= 64'h0000_00db_97ec_a864;
		wait_frame(f0);
		rd_chk(ADDR_RX_LOW, 32'h6813_579b, '1, "rx_cur");
		wait_frame(f0 + 1);
		chk("both_frames", 64'(f0 + 2), 64'(frames));
		chk("cov_sent", 64'h0000_00ef_1122_3344, rx);
		rd_chk(ADDR_RX_LOW, 32'h97ec_a864, '1, "rx_cov");
		rd_chk(ADDR_EVENTS, 32'h0200_0000, 32'h0200_0000, "cov_done");
		// Second reset in mid-run
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd_chk(ADDR_SPI_CONF, 32'h0, '1, "conf_rst");
		chk("cs_rst", 64'h1, {63'h0, cs_n});
		end_sim();
	end
endmodule
